// File: rtl/eds_page_pkg.sv
// Constants and carrier types for the extended data space paging logic.
package xpage_pkg;

    // ======================================================================
    // Widths
    // ======================================================================
    localparam int unsigned DADDR_W     = 16;
    localparam int unsigned DATA_W      = 16;
    localparam int unsigned OFS_W       = 15;
    localparam int unsigned RPAGE_W     = 10;
    localparam int unsigned WPAGE_W     = 9;
    localparam int unsigned XADDR_W     = 24;
    localparam int unsigned PMEM_ADDR_W = 23;
    localparam int unsigned PMEM_PAGE_W = PMEM_ADDR_W - OFS_W;

    // ======================================================================
    // Field positions and reset values
    // ======================================================================
    localparam int unsigned        UPPER_HALF_BIT = 15;
    localparam logic [RPAGE_W-1:0] PMEM_PAGE_MIN  = 10'h200;
    localparam logic [RPAGE_W-1:0] RPAGE_RST      = 10'h001;
    localparam logic [WPAGE_W-1:0] WPAGE_RST      = 9'h001;
    localparam logic [WPAGE_W-1:0] BASE_PAGE      = 9'h000;

    // ======================================================================
    // Carriers
    // ======================================================================
    typedef struct packed {
        logic                 req;
        logic                 we;
        logic [DADDR_W-1:0]   addr;
        logic [DATA_W-1:0]    wdata;
    } core_acc_t;

    typedef struct packed {
        logic                   dmem_req;
        logic                   dmem_we;
        logic                   dmem_paged;
        logic [XADDR_W-1:0]     dmem_addr;
        logic                   pmem_req;
        logic [PMEM_ADDR_W-1:0] pmem_addr;
    } mem_acc_t;

endpackage : xpage_pkg

// File: rtl/eds_page_xlate.sv
// Combinational address translation for one core access.
`timescale 1ns/100ps
module xpage_xlate (
    // Page registers
    input  wire logic [xpage_pkg::RPAGE_W-1:0] i_rpage,
    input  wire logic [xpage_pkg::WPAGE_W-1:0] i_wpage,
    // Core access
    input  wire xpage_pkg::core_acc_t          i_acc,
    // Translated access
    output      xpage_pkg::mem_acc_t           o_mem
);
    import xpage_pkg::*;

    logic                 upper;
    logic [OFS_W-1:0]     ofs;

    always_comb begin
        upper = i_acc.addr[UPPER_HALF_BIT];
        ofs   = i_acc.addr[OFS_W-1:0];
        o_mem = '0;
        if (i_acc.req) begin
            if (!upper) begin
                o_mem.dmem_req  = 1'b1;
                o_mem.dmem_we   = i_acc.we;
                o_mem.dmem_addr = {BASE_PAGE, ofs};
            end else if (i_acc.we) begin
                // Writes never reach program space; the write page is too narrow to name it.
                o_mem.dmem_req   = 1'b1;
                o_mem.dmem_we    = 1'b1;
                o_mem.dmem_paged = 1'b1;
                o_mem.dmem_addr  = {i_wpage, ofs};
            end else if (i_rpage >= PMEM_PAGE_MIN) begin
                o_mem.pmem_req  = 1'b1;
                o_mem.pmem_addr = {i_rpage[PMEM_PAGE_W-1:0], ofs};
            end else begin
                o_mem.dmem_req   = 1'b1;
                o_mem.dmem_paged = 1'b1;
                o_mem.dmem_addr  = {i_rpage[WPAGE_W-1:0], ofs};
            end
        end
    end

endmodule : xpage_xlate

// File: rtl/eds_page.sv
// Extended data space paging: page registers and registered address translation.
`timescale 1ns/100ps
module extended_data_space_paging (
    // Clock and reset
    input  wire logic                            i_sys_clk,
    input  wire logic                            i_rst_b,
    // Page register loads from the core
    input  wire logic                            i_rpage_we,
    input  wire logic                            i_wpage_we,
    input  wire logic [xpage_pkg::RPAGE_W-1:0]   i_page_wdata,
    // Core access
    input  wire xpage_pkg::core_acc_t            i_acc,
    // Page register state
    output      logic [xpage_pkg::RPAGE_W-1:0]   o_rpage,
    output      logic [xpage_pkg::WPAGE_W-1:0]   o_wpage,
    // Memory side
    output      xpage_pkg::mem_acc_t             o_mem,
    output      logic [xpage_pkg::DATA_W-1:0]    o_wdata
);
    import xpage_pkg::*;

    // ======================================================================
    // State
    // ======================================================================
    // All the block remembers sits in one struct, so reset and update each touch it in one place.
    typedef struct packed {
        logic [RPAGE_W-1:0] rpage;
        logic [WPAGE_W-1:0] wpage;
        mem_acc_t           mem;
        logic [DATA_W-1:0]  wdata;
    } page_state_t;

    page_state_t st_r;
    page_state_t st_nxt;
    mem_acc_t    xl_mem;

    // ======================================================================
    // Translation
    // ======================================================================
    // Translation uses the page values held before this cycle's load, so a load and an access
    // in the same cycle see the old page; this keeps the path short at the cost of one cycle.
    xpage_xlate u_xlate (
        .i_rpage (st_r.rpage),
        .i_wpage (st_r.wpage),
        .i_acc   (i_acc),
        .o_mem   (xl_mem)
    );

    // ======================================================================
    // Next state
    // ======================================================================
    // Both page loads share one data bus, so loading both in one cycle gives them the same page;
    // the write page simply drops the top bit, which keeps it out of program space.
    always_comb begin
        st_nxt     = st_r;
        st_nxt.mem = xl_mem;
        st_nxt.wdata = (i_acc.req && i_acc.we) ? i_acc.wdata : st_r.wdata;
        if (i_rpage_we) begin
            st_nxt.rpage = i_page_wdata;
        end
        if (i_wpage_we) begin
            st_nxt.wpage = i_page_wdata[WPAGE_W-1:0];
        end
    end

    // ======================================================================
    // Registers
    // ======================================================================
    // The reset branch loads constants only, so the reset path never depends on live logic.
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_r       <= '0;
            st_r.rpage <= RPAGE_RST;
            st_r.wpage <= WPAGE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ======================================================================
    // Outputs
    // ======================================================================
    // Every output is a flop, so the memory arrays see a clean request one cycle after the core;
    // the price is one cycle of latency on every access.
    assign o_rpage = st_r.rpage;
    assign o_wpage = st_r.wpage;
    assign o_mem   = st_r.mem;
    assign o_wdata = st_r.wdata;

    // ======================================================================
    // Assertions: access routing
    // ======================================================================
    // Every check here lives in the one clock domain and is silent while reset holds.
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);

    // A lower-half access must never pick up a page, whatever the page registers hold.
    AST_LOWER_DIRECT: assert property (
        i_acc.req && !i_acc.addr[UPPER_HALF_BIT]
            |=> o_mem.dmem_req && !o_mem.dmem_paged && !o_mem.pmem_req
            && o_mem.dmem_addr == {BASE_PAGE, $past(i_acc.addr[OFS_W-1:0])})
        else $error("Lower-half access was paged.");

    // The direction of a lower-half access passes through unchanged.
    AST_LOWER_WE: assert property (
        i_acc.req && !i_acc.addr[UPPER_HALF_BIT]
            |=> o_mem.dmem_we == $past(i_acc.we))
        else $error("Lower-half access lost its direction.");

    // An unpaged data request always lands in the base page.
    AST_BASE_PAGE: assert property (
        o_mem.dmem_req && !o_mem.dmem_paged
            |-> o_mem.dmem_addr[XADDR_W-1:OFS_W] == BASE_PAGE)
        else $error("Unpaged request left the base page.");

    // A read page at or above the threshold turns paged reads towards program memory.
    AST_READ_PMEM: assert property (
        i_acc.req && !i_acc.we && i_acc.addr[UPPER_HALF_BIT] && st_r.rpage >= PMEM_PAGE_MIN
            |=> o_mem.pmem_req && !o_mem.dmem_req)
        else $error("High read page did not select program memory.");

    // Program memory and data memory are never asked in the same cycle.
    AST_ONE_TARGET: assert property (
        !(o_mem.dmem_req && o_mem.pmem_req))
        else $error("Both memories requested at once.");

    // The program address joins the low read page bits to the offset of a read.
    AST_PMEM_ADDR: assert property (
        o_mem.pmem_req
            |-> o_mem.pmem_addr == {$past(st_r.rpage[PMEM_PAGE_W-1:0]), $past(i_acc.addr[OFS_W-1:0])}
            && $past(i_acc.we) == 1'b0)
        else $error("Program space address not formed from the read page.");

    // Only a read page at or above the threshold may reach program memory.
    AST_PMEM_PAGE: assert property (
        o_mem.pmem_req |-> $past(st_r.rpage) >= PMEM_PAGE_MIN)
        else $error("Program memory reached below the threshold page.");

    // A paged read below the threshold uses the read page in the extended data space.
    AST_READ_XDATA: assert property (
        i_acc.req && !i_acc.we && i_acc.addr[UPPER_HALF_BIT] && st_r.rpage < PMEM_PAGE_MIN
            |=> o_mem.dmem_req && o_mem.dmem_paged && !o_mem.dmem_we
            && o_mem.dmem_addr == {$past(st_r.rpage[WPAGE_W-1:0]), $past(i_acc.addr[OFS_W-1:0])})
        else $error("Paged data read address wrong.");

    // A paged write uses the write page and nothing of the read page.
    AST_WRITE_XDATA: assert property (
        i_acc.req && i_acc.we && i_acc.addr[UPPER_HALF_BIT]
            |=> o_mem.dmem_we && o_mem.dmem_paged
            && o_mem.dmem_addr == {$past(st_r.wpage), $past(i_acc.addr[OFS_W-1:0])})
        else $error("Paged write did not use the write page.");

    // No write of any kind may reach program memory.
    AST_WRITE_NO_PMEM: assert property (
        i_acc.req && i_acc.we |=> !o_mem.pmem_req && o_mem.dmem_req && o_wdata == $past(i_acc.wdata))
        else $error("Write reached program memory.");

    // Write data only moves with a write, so the data memory may sample it late.
    AST_WDATA_HOLD: assert property (
        !(i_acc.req && i_acc.we) |=> $stable(o_wdata))
        else $error("Write data changed without a write.");

    // A write strobe never appears without a data request to carry it.
    AST_WE_QUAL: assert property (
        o_mem.dmem_we |-> o_mem.dmem_req)
        else $error("Write strobe without a data request.");

    // Every core access is answered by exactly one memory one cycle later.
    AST_ANSWER: assert property (
        i_acc.req |=> o_mem.dmem_req || o_mem.pmem_req)
        else $error("Core access produced no memory request.");

    // No memory request appears without a core access behind it.
    AST_IDLE: assert property (
        !i_acc.req |=> !o_mem.dmem_req && !o_mem.pmem_req)
        else $error("Memory request without a core access.");

    // ======================================================================
    // Assertions: page registers
    // ======================================================================
    // A read page load leaves the write page alone.
    AST_RPAGE_INDEP: assert property (
        i_rpage_we && !i_wpage_we
            |=> o_wpage == $past(o_wpage) && o_rpage == $past(i_page_wdata))
        else $error("Read page load disturbed the write page.");

    // A write page load leaves the read page alone.
    AST_WPAGE_INDEP: assert property (
        i_wpage_we && !i_rpage_we
            |=> o_rpage == $past(o_rpage) && o_wpage == $past(i_page_wdata[WPAGE_W-1:0]))
        else $error("Write page load disturbed the read page.");

    // Both loads in one cycle share the data; the write page keeps only its low bits.
    AST_BOTH_LOAD: assert property (
        i_rpage_we && i_wpage_we
            |=> o_rpage == $past(i_page_wdata) && o_wpage == $past(i_page_wdata[WPAGE_W-1:0]))
        else $error("Shared page load went wrong.");

    // A page window stays where it is until software moves it.
    AST_PAGE_HOLD: assert property (
        !i_rpage_we && !i_wpage_we |=> $stable(o_rpage) && $stable(o_wpage))
        else $error("Page register changed without a load.");

    // ======================================================================
    // Cover
    // ======================================================================
    // These mark that the program read, paged write and base routes and a load followed by its first use have been seen.
    COV_PMEM_READ:   cover property (o_mem.pmem_req);
    COV_XDATA_WRITE: cover property (o_mem.dmem_req && o_mem.dmem_we && o_mem.dmem_paged);
    COV_BASE:        cover property (o_mem.dmem_req && !o_mem.dmem_paged);
    COV_LOAD_USE:    cover property (i_rpage_we ##1 (i_acc.req && !i_acc.we && i_acc.addr[UPPER_HALF_BIT]));
    COV_BOTH_LOAD:   cover property (i_rpage_we && i_wpage_we);

endmodule : extended_data_space_paging

// File: tb/eds_page_core_model.sv
// Core-side model that presents load and store accesses to the paging logic.
`timescale 1ns/100ps
module xpage_core_model (
    // Reset
    input  wire logic                 i_rst_b,
    // Commanded access
    input  wire xpage_pkg::core_acc_t i_cmd,
    // Access to the paging logic
    output      xpage_pkg::core_acc_t o_acc
);
    import xpage_pkg::*;
    // ======================================================================
    // Request gating
    // ======================================================================
    // No request is shown while reset holds, so none can be silently lost.
    always_comb begin
        o_acc     = i_cmd;
        o_acc.req = i_cmd.req & i_rst_b;
    end
endmodule : xpage_core_model

// File: tb/eds_page_tb_top.sv
// Self-checking testbench for the extended data space paging logic.
`timescale 1ns/100ps
module extended_data_space_paging_tb_top;
    import xpage_pkg::*;
    // ======================================================================
    // Signals and model state
    // ======================================================================
    logic               i_sys_clk = 1'b0;
    logic               i_rst_b   = 1'b0;
    logic               rpage_we  = 1'b0;
    logic               wpage_we  = 1'b0;
    logic [RPAGE_W-1:0] page_wdata = '0;
    core_acc_t          cmd = '0;
    core_acc_t          acc;
    logic [RPAGE_W-1:0] rpage_o;
    logic [WPAGE_W-1:0] wpage_o;
    mem_acc_t           mem_o;
    logic [DATA_W-1:0]  wdata_o;
    mem_acc_t           exp;
    logic [DATA_W-1:0]  exp_wd;
    int                 rp, wp, mismatches, compares, cycles;
    logic [RPAGE_W-1:0] pages [4] = '{10'h000, 10'h1ff, 10'h200, 10'h3ff};

    always #5 i_sys_clk = ~i_sys_clk;

    xpage_core_model core (.i_rst_b(i_rst_b), .i_cmd(cmd), .o_acc(acc));
    extended_data_space_paging uut (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_rpage_we(rpage_we),
        .i_wpage_we(wpage_we), .i_page_wdata(page_wdata), .i_acc(acc), .o_rpage(rpage_o),
        .o_wpage(wpage_o), .o_mem(mem_o), .o_wdata(wdata_o));

    // ======================================================================
    // Reference model, one result per edge
    // ======================================================================
    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rp = 1; wp = 1; exp = '0; exp_wd = '0;
        end else begin
            exp = '0;
            if (acc.req) begin
                if (acc.we) exp_wd = acc.wdata;
                exp.dmem_we   = acc.we;
                exp.dmem_addr = {9'h000, acc.addr[14:0]};
                if (!acc.addr[15]) exp.dmem_req = 1'b1;
                else if (!acc.we && rp >= 32'h200) begin
                    exp.pmem_req = 1'b1; exp.dmem_we = 1'b0;
                    exp.pmem_addr = {rp[7:0], acc.addr[14:0]};
                end else begin
                    exp.dmem_req = 1'b1; exp.dmem_paged = 1'b1;
                    exp.dmem_addr = {acc.we ? wp[8:0] : rp[8:0], acc.addr[14:0]};
                end
            end
            if (rpage_we) rp = page_wdata;
            if (wpage_we) wp = page_wdata[8:0];
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            mismatches++;
            $display("ERROR %0t: output differs from model, seen %h expected %h", $time, seen, want);
        end
    endtask : chk

    always @(negedge i_sys_clk) begin
        chk(rpage_o, rp[9:0]);
        chk(wpage_o, wp[8:0]);
        chk(mem_o.pmem_req, exp.pmem_req);
        chk(mem_o.dmem_req, exp.dmem_req);
        chk(mem_o.dmem_paged, exp.dmem_paged);
        chk(wdata_o, exp_wd);
        if (exp.dmem_req) chk({mem_o.dmem_we, mem_o.dmem_addr}, {exp.dmem_we, exp.dmem_addr});
        if (exp.pmem_req) chk(mem_o.pmem_addr, exp.pmem_addr);
    end

    // ======================================================================
    // Stimulus and closing
    // ======================================================================
    task automatic drive(input logic rw, ww, input logic [9:0] pd, input logic rq, we, input logic [15:0] a, d);
        @(posedge i_sys_clk);
        rpage_we <= rw; wpage_we <= ww; page_wdata <= pd;
        cmd <= '{req: rq, we: we, addr: a, wdata: d};
    endtask : drive

    task automatic end_sim();
        if (mismatches == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_sim

    // The ceiling leaves ample margin over the roughly 500 cycles the tests need.
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            end_sim();
        end
    end

    initial begin
        void'($urandom(99455));
        repeat (3) @(posedge i_sys_clk);
        i_rst_b <= 1'b1;
        foreach (pages[i]) begin
            drive(1, 1, pages[i], 0, 0, 16'h0000, 16'h0000);
            drive(0, 0, 0, 1, 0, 16'h8000 | 16'($urandom), 16'h0000);
            drive(0, 0, 0, 1, 1, 16'hfffe, 16'($urandom));
            drive(0, 0, 0, 1, 0, 16'h7fff, 16'h0000);
        end
        // A load and an access in one cycle: the access must see the old page.
        drive(1, 0, 10'h200, 1, 0, 16'h8004, 16'h0000);
        drive(0, 0, 0, 1, 0, 16'h8004, 16'h0000);
        repeat (400) drive($urandom_range(0, 3) == 0, $urandom_range(0, 3) == 0, 10'($urandom),
            1'($urandom), 1'($urandom), 16'($urandom), 16'($urandom));
        @(posedge i_sys_clk);
        i_rst_b <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        i_rst_b <= 1'b1;
        repeat (40) drive(0, 0, 0, 1'($urandom), 1'($urandom), 16'($urandom), 16'($urandom));
        drive(0, 0, 0, 0, 0, 16'h0000, 16'h0000);
        repeat (2) @(posedge i_sys_clk);
        end_sim();
    end
endmodule : extended_data_space_paging_tb_top
